// ===== shared/qdac_pkg.sv
package qdac_pkg;

	// ********************************************************************
	// Serial word layout.
	// ********************************************************************
	localparam int        WORD_BITS    = 24;
	localparam int        CNT_W        = 5;
	localparam logic [4:0] WORD_BITS_C = 5'h18;
	localparam int        SEL_HI       = 21;
	localparam int        SEL_LO       = 19;
	localparam int        ADDR_HI      = 18;
	localparam int        ADDR_LO      = 16;
	localparam int        PAY_HI       = 15;
	localparam int        PAY_LO       = 0;
	localparam int        NUM_CHAN     = 4;

	// ********************************************************************
	// Register-select codes and channel address codes.
	// ********************************************************************
	localparam logic [2:0] SEL_FUNC   = 3'h0;
	localparam logic [2:0] SEL_CODE   = 3'h2;
	localparam logic [2:0] SEL_RANGE  = 3'h3;
	localparam logic [2:0] SEL_GAIN   = 3'h4;
	localparam logic [2:0] SEL_OFFSET = 3'h5;
	localparam logic [2:0] ADDR_ALL   = 3'h4;
	localparam logic [2:0] FUNC_CTRL  = 3'h1;

	// ********************************************************************
	// Function control payload bit positions.
	// ********************************************************************
	localparam int FB_LGND   = 5;
	localparam int FB_DIR1   = 4;
	localparam int FB_VAL1   = 3;
	localparam int FB_DIR0   = 2;
	localparam int FB_VAL0   = 1;
	localparam int FB_SDODIS = 0;

	// ********************************************************************
	// Reset values of the per-channel registers.
	// ********************************************************************
	localparam logic [15:0] RST_CODE   = 16'h0000;
	localparam logic [1:0]  RST_RANGE  = 2'h0;
	localparam logic [5:0]  RST_GAIN   = 6'h20;
	localparam logic [7:0]  RST_OFFSET = 8'h80;

	// Range codes: 00 is +/-10 V, 01 is +/-10.25 V, 10 is +/-10.5 V.
	localparam logic [1:0] RANGE_10V0  = 2'h0;
	localparam logic [1:0] RANGE_10V25 = 2'h1;
	localparam logic [1:0] RANGE_10V5  = 2'h2;

	typedef enum logic {QDAC_IDLE, QDAC_SHIFT} qdac_phase_e;

	typedef struct packed {
		logic [15:0] channel_code;
		logic [1:0]  channel_range_select;
		logic [5:0]  channel_gain_trim;
		logic [7:0]  channel_offset_trim;
	} qdac_chan_s;

	typedef struct packed {
		logic [1:0] dir;
		logic [1:0] val;
	} qdac_gpio_s;

endpackage : qdac_pkg

// ===== rtl/qdac_regdec.sv
`timescale 1ns/10ps
// Behaviour
// - Select 010 writes the 16-bit payload into the addressed channel code register.
// - Select 011 stores payload bits 1..0 as range select; higher bits ignored.
// - Range code 00, 01, 10 give spans of 10, 10.25, 10.5 V.
// - Select 100 loads payload bits 5..0 as gain trim; higher bits ignored.
// - Gain trim 111111 is +31, 100000 none, 000000 is -32 LSB.
// - Select 101 loads payload bits 7..0 as offset trim; higher bits ignored.
// - Offset trim steps eighth LSB; 10000000 means no adjustment.
// - Output clamped until supplies stable and a code word was written.
// - External reset low disconnects the amplifier and clamps the output.
// - Supply detector state is driven on a reset output pin.
// - Two GPIO pins, each input or output, driven and read serially.
// - Ground compensation enable bit corrects outputs for local ground offset.
// - Address 000 to 011 picks one channel; 100 writes all four.
module qdac_regdec
	import qdac_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_ce,
	// Serial host pins.
	input  wire logic                 i_sclk,
	input  wire logic                 i_sync_n,
	input  wire logic                 i_sdin,
	output logic                      o_serial_data_out,
	output logic                      o_serial_data_out_oe_n,
	// Supply control.
	input  wire logic                 i_ext_reset_in_n,
	input  wire logic                 i_supply_stable,
	output logic                      o_supply_detect_out,
	output logic [NUM_CHAN-1:0]       o_amp_connect_gate,
	output logic [NUM_CHAN-1:0]       o_output_clamp_gate,
	// General-purpose pins.
	input  wire logic [1:0]           i_gpio_pin,
	output logic [1:0]                o_gpio_pin,
	output logic [1:0]                o_gpio_pin_oe_n,
	// Channel settings to the converter cores.
	output qdac_chan_s [NUM_CHAN-1:0] o_chan,
	output logic                      o_local_gnd_comp_en
);

	// ********************************************************************
	// State.
	// ********************************************************************
	typedef struct packed {
		logic [1:0]                sclk_s;
		logic                      sclk_prev;
		logic [1:0]                sync_s;
		logic [1:0]                sdin_s;
		logic [1:0]                ext_s;
		logic [1:0]                sup_s;
		logic [1:0]                gp1_s;
		logic [1:0]                gp0_s;
		qdac_phase_e               phase;
		logic [CNT_W-1:0]          cnt;
		logic [WORD_BITS-1:0]      shift;
		logic [WORD_BITS-1:0]      rdbk;
		logic                      serial_data_out;
		logic                      sdo_dis;
		logic                      lgnd;
		qdac_gpio_s                gpio;
		logic [NUM_CHAN-1:0]       live;
		logic [NUM_CHAN-1:0]       clamp;
		logic                      sdo_oe_n;
		qdac_chan_s [NUM_CHAN-1:0] chan;
	} qdac_state_s;

	qdac_state_s st_q;
	qdac_state_s st_d;

	// Decoded fields of the word just received.
	logic [2:0]  w_sel;
	logic [2:0]  w_addr;
	logic [15:0] w_pay;
	logic        sclk_fall;
	logic        sclk_rise;
	logic [1:0]  pin_lvl;

	// ********************************************************************
	// Next-state logic.
	// ********************************************************************

	// Sync first stages feed only the second stage, and sync_s[0] also the sdo_oe_n flop; edges use the second stage and its delay.
	always_comb begin
		st_d = st_q;
		st_d.sclk_s = {st_q.sclk_s[0], i_sclk};
		st_d.sclk_prev = st_q.sclk_s[1];
		st_d.sync_s = {st_q.sync_s[0], i_sync_n};
		st_d.sdin_s = {st_q.sdin_s[0], i_sdin};
		st_d.ext_s = {st_q.ext_s[0], i_ext_reset_in_n};
		st_d.sup_s = {st_q.sup_s[0], i_supply_stable};
		st_d.gp1_s = {st_q.gp1_s[0], i_gpio_pin[1]};
		st_d.gp0_s = {st_q.gp0_s[0], i_gpio_pin[0]};

		sclk_fall = st_q.sclk_prev & ~st_q.sclk_s[1];
		sclk_rise = ~st_q.sclk_prev & st_q.sclk_s[1];
		w_sel = st_q.shift[SEL_HI:SEL_LO];
		w_addr = st_q.shift[ADDR_HI:ADDR_LO];
		w_pay = st_q.shift[PAY_HI:PAY_LO];

		// Sampled pin levels; a pin set as an output reads back its driven value instead.
		pin_lvl = {st_q.gp1_s[1], st_q.gp0_s[1]};

		case (st_q.phase)
			QDAC_IDLE: begin
				if (!st_q.sync_s[1]) begin
					st_d.phase = QDAC_SHIFT;
					st_d.cnt = '0;
				end
			end
			QDAC_SHIFT: begin
				// Bits are taken on the falling serial clock, MSB first.
				if (sclk_fall && st_q.cnt != WORD_BITS_C) begin
					st_d.shift = {st_q.shift[WORD_BITS-2:0], st_q.sdin_s[1]};
					st_d.cnt = st_q.cnt + 5'h01;
				end
				// Readback bits change on the rising edge so the host sees them settled.
				if (sclk_rise) begin
					st_d.serial_data_out = st_q.rdbk[WORD_BITS-1];
					st_d.rdbk = {st_q.rdbk[WORD_BITS-2:0], 1'b0};
				end
				if (st_q.sync_s[1]) begin
					st_d.phase = QDAC_IDLE;
					// A frame shorter than 24 bits is dropped whole; bits after the 24th are ignored and the word is kept.
					// Nothing marks the loss, so the host must resend the whole word.
					if (st_q.cnt == WORD_BITS_C) begin
						for (int i = 0; i < NUM_CHAN; i++) begin
							if (w_addr == 3'(i) || w_addr == ADDR_ALL) begin
								case (w_sel)
									SEL_CODE: begin
										st_d.chan[i].channel_code = w_pay;
										st_d.live[i] = st_q.sup_s[1] & st_q.ext_s[1];
									end
									// Code 11 is kept as written.
									SEL_RANGE: st_d.chan[i].channel_range_select = w_pay[1:0];
									SEL_GAIN: st_d.chan[i].channel_gain_trim = w_pay[5:0];
									SEL_OFFSET: st_d.chan[i].channel_offset_trim = w_pay[7:0];
									default: ;
								endcase
							end
						end
						// A value written to a pin set as input is kept and shows once it turns output.
						if (w_sel == SEL_FUNC && w_addr == FUNC_CTRL) begin
							st_d.lgnd = w_pay[FB_LGND];
							st_d.gpio.dir = {w_pay[FB_DIR1], w_pay[FB_DIR0]};
							st_d.gpio.val = {w_pay[FB_VAL1], w_pay[FB_VAL0]};
							st_d.sdo_dis = w_pay[FB_SDODIS];
						end
					end
					// Next frame shifts out the function state with the pin levels sampled as this frame ends.
					// The word just taken is already in st_d, so a function write is read
					// back by the very next frame rather than one frame late.
					st_d.rdbk = '0;
					st_d.rdbk[SEL_LO-1:ADDR_LO] = FUNC_CTRL;
					st_d.rdbk[FB_LGND] = st_d.lgnd;
					st_d.rdbk[FB_DIR1] = st_d.gpio.dir[1];
					st_d.rdbk[FB_VAL1] = st_d.gpio.dir[1] ? st_d.gpio.val[1] : pin_lvl[1];
					st_d.rdbk[FB_DIR0] = st_d.gpio.dir[0];
					st_d.rdbk[FB_VAL0] = st_d.gpio.dir[0] ? st_d.gpio.val[0] : pin_lvl[0];
					st_d.rdbk[FB_SDODIS] = st_d.sdo_dis;
				end
			end
			default: st_d.phase = QDAC_IDLE;
		endcase

		// Supply loss or external reset clamps every channel at once; only a fresh
		// code write releases it, so a glitch never restores a stale output.
		if (!st_q.sup_s[1] || !st_q.ext_s[1]) begin
			st_d.live = '0;
		end

		// Pin-facing strobes are registered copies of their final next values, so they
		// switch on the same edge as before but never glitch through logic.
		st_d.clamp = ~st_d.live;
		st_d.sdo_oe_n = st_d.sdo_dis | st_d.sync_s[1];
	end

	// ********************************************************************
	// State register.
	// ********************************************************************

	// Clock enable low freezes everything, synchronisers included.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
			// Link pins start at their idle levels so no false edge follows reset.
			st_q.sclk_s <= 2'h3;
			st_q.sclk_prev <= 1'b1;
			st_q.sync_s <= 2'h3;
			st_q.clamp <= '1;
			st_q.sdo_oe_n <= 1'b1;
			st_q.ext_s <= 2'h0;
			st_q.phase <= QDAC_IDLE;
			for (int i = 0; i < NUM_CHAN; i++) begin
				st_q.chan[i].channel_code <= RST_CODE;
				st_q.chan[i].channel_range_select <= RST_RANGE;
				st_q.chan[i].channel_gain_trim <= RST_GAIN;
				st_q.chan[i].channel_offset_trim <= RST_OFFSET;
			end
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end

	// ********************************************************************
	// Outputs, each a flop of the state.
	// ********************************************************************
	assign o_supply_detect_out    = st_q.sup_s[1];
	assign o_amp_connect_gate     = st_q.live;
	assign o_output_clamp_gate    = st_q.clamp;
	assign o_gpio_pin             = st_q.gpio.val;
	assign o_gpio_pin_oe_n        = ~st_q.gpio.dir;
	assign o_chan                 = st_q.chan;
	assign o_local_gnd_comp_en    = st_q.lgnd;
	assign o_serial_data_out      = st_q.serial_data_out;
	// The readback enable is its own flop, so the line never flickers at frame edges.
	assign o_serial_data_out_oe_n = st_q.sdo_oe_n;

endmodule : qdac_regdec

// ===== verif/qdac_host_model.sv
`timescale 1ns/10ps
// ****************************************************
// Host end of the three-wire link.
// ****************************************************
module qdac_host_model (
	// Pacing clock and readback line.
	input  wire logic i_mclk,
	input  wire logic i_sdo,
	// Link lines towards the block.
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_sdin
);
	// The serial clock idles high and stands still between frames.
	initial begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_sdin = 1'b0;
	end
	// One word MSB first, eight clocks a bit; readback taken late in each high phase.
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		r = '0;
		@(negedge i_mclk);
		o_sync_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_sdin = w[i];
			repeat (4) @(negedge i_mclk);
			if (i < 23) r = {r[22:0], i_sdo};
			o_sclk = 1'b0;
			repeat (4) @(negedge i_mclk);
			o_sclk = 1'b1;
		end
		repeat (4) @(negedge i_mclk);
		r = {r[22:0], i_sdo};
		o_sync_n = 1'b1;
		o_sdin = ~o_sdin; // A released line must not show a stale bit.
		repeat (10) @(negedge i_mclk);
	endtask : xfer
endmodule : qdac_host_model

// ===== verif/qdac_regdec_props.sv
`timescale 1ns/10ps
// ****************************************************
// Pin relations of the channel register decoder.
// ****************************************************
module qdac_regdec_props
	import qdac_pkg::*;
(
	// Watched pins.
	input wire logic              i_mclk,
	input wire logic              i_rst_n,
	input wire logic              i_sync_n,
	input wire logic              i_ext_reset_in_n,
	input wire logic              i_supply_stable,
	input wire logic              o_supply_detect_out,
	input wire logic [3:0]        o_amp_connect_gate,
	input wire logic [3:0]        o_output_clamp_gate,
	input wire logic              o_serial_data_out_oe_n,
	input wire logic [1:0]        o_gpio_pin_oe_n,
	input wire qdac_chan_s [3:0]  o_chan,
	input wire logic              o_local_gnd_comp_en
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Sync pipeline allows three clocks before a fault shows.
	a_clamp_inverse: assert property (o_output_clamp_gate == ~o_amp_connect_gate)
		else $error("clamp not inverse of amp");
	a_ext_clamps: assert property (!i_ext_reset_in_n [*4] |-> o_amp_connect_gate == 4'h0)
		else $error("amp left on under ext reset");
	a_supply_clamps: assert property (!i_supply_stable [*4] |-> o_amp_connect_gate == 4'h0)
		else $error("amp left on with supply low");
	a_amp_after_word: assert property (|(o_amp_connect_gate & ~$past(o_amp_connect_gate))
		|-> i_sync_n && $past(i_supply_stable, 3) && $past(i_ext_reset_in_n, 3))
		else $error("amp connected without valid word");
	a_detect_falls: assert property ($fell(i_supply_stable) |-> ##[1:4] !o_supply_detect_out)
		else $error("supply detect out late");
	a_chan_quiet: assert property (!$stable(o_chan) |-> i_sync_n)
		else $error("channel changed inside frame");
	a_ctl_quiet: assert property (!$stable({o_gpio_pin_oe_n, o_local_gnd_comp_en}) |-> i_sync_n)
		else $error("control changed inside frame");
	a_sdo_idle: assert property (i_sync_n [*6] |-> o_serial_data_out_oe_n)
		else $error("readback driven outside frame");
endmodule : qdac_regdec_props

bind qdac_regdec qdac_regdec_props u_props (.i_mclk, .i_rst_n, .i_sync_n, .i_ext_reset_in_n,
	.i_supply_stable, .o_supply_detect_out, .o_amp_connect_gate, .o_output_clamp_gate,
	.o_serial_data_out_oe_n, .o_gpio_pin_oe_n, .o_chan, .o_local_gnd_comp_en);

// ===== verif/qdac_regdec_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module qdac_regdec_test;
	import qdac_pkg::*;
	logic             i_mclk, i_rst_n, sclk, sync_n, sdin, serial_data_out, sdo_oe_n, ext_n, sup, sup_o, lgnd;
	logic [3:0]       amp, clamp, ea;
	logic [1:0]       gp_in, gp_o, gp_oe_n;
	logic [23:0]      rd;
	qdac_chan_s [3:0] chan;
	qdac_chan_s       e [4];
	int               err_count, cmp_count, cyc;
	// Pin 1 has a pull-up, pin 0 is held low by the bench while an input.
	assign gp_in = {gp_oe_n[1] ? 1'b1 : gp_o[1], gp_oe_n[0] ? 1'b0 : gp_o[0]};
	qdac_regdec DUT (.i_mclk, .i_rst_n, .i_ce(1'b1), .i_sclk(sclk), .i_sync_n(sync_n),
		.i_sdin(sdin), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe_n(sdo_oe_n),
		.i_ext_reset_in_n(ext_n), .i_supply_stable(sup), .o_supply_detect_out(sup_o),
		.o_amp_connect_gate(amp), .o_output_clamp_gate(clamp), .i_gpio_pin(gp_in),
		.o_gpio_pin(gp_o), .o_gpio_pin_oe_n(gp_oe_n), .o_chan(chan), .o_local_gnd_comp_en(lgnd));
	qdac_host_model u_host (.i_mclk, .i_sdo(serial_data_out), .o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// Hang guard; the whole sequence needs about 4600 clocks.
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	// Send a word, update the expected channels, compare every channel and gate.
	task automatic wr(input logic [23:0] w);
		u_host.xfer(w, rd);
		for (int c = 0; c < 4; c++) begin
			if (w[18:16] == c[2:0] || w[18:16] == ADDR_ALL) begin
				case (w[21:19])
					SEL_CODE: begin
						e[c].channel_code = w[15:0];
						ea[c] = ea[c] | (sup & ext_n);
					end
					SEL_RANGE: e[c].channel_range_select = w[1:0];
					SEL_GAIN: e[c].channel_gain_trim = w[5:0];
					SEL_OFFSET: e[c].channel_offset_trim = w[7:0];
					default: ;
				endcase
			end
			`CHK(chan[c], e[c])
		end
		`CHK({amp, clamp}, {ea, ~ea})
	endtask : wr
	initial begin
		{i_rst_n, ea, err_count, cmp_count, cyc} = '0;
		{ext_n, sup} = 2'b11;
		for (int c = 0; c < 4; c++) e[c] = {RST_CODE, RST_RANGE, RST_GAIN, RST_OFFSET};
		repeat (4) @(negedge i_mclk);
		i_rst_n = 1'b1;
		repeat (6) @(negedge i_mclk);
		for (int c = 0; c < 4; c++) `CHK(chan[c], e[c])
		`CHK({amp, gp_oe_n, lgnd, sdo_oe_n}, 8'h0d)
		$display("reset test done");
		wr({5'h03, 3'h4, 16'hfffe});
		for (int c = 0; c < 4; c++) wr({5'h02, c[2:0], 16'h8001 + 16'(c) * 16'h1111});
		for (int r = 0; r < 4; r++) wr({5'h03, 3'h1, 14'h3fff, r[1:0]});
		wr({5'h04, 3'h4, 16'hffdf});
		wr({5'h04, 3'h2, 16'h0000});
		wr({5'h05, 3'h3, 16'hff7e});
		wr({5'h05, 3'h0, 16'h0000});
		wr({5'h1a, 3'h0, 16'h1234});
		wr({5'h07, 3'h0, 16'hffff});
		wr({5'h02, 3'h5, 16'h5555});
		$display("register test done");
		ext_n = 1'b0;
		ea = 4'h0;
		repeat (6) @(negedge i_mclk);
		`CHK({amp, clamp}, 8'h0f)
		wr({5'h02, 3'h0, 16'h0100});
		ext_n = 1'b1;
		wr({5'h02, 3'h4, 16'h0200});
		sup = 1'b0;
		ea = 4'h0;
		repeat (6) @(negedge i_mclk);
		`CHK({sup_o, amp}, 5'h00)
		sup = 1'b1;
		repeat (6) @(negedge i_mclk);
		`CHK(sup_o, 1'b1)
		wr({5'h02, 3'h1, 16'h0300});
		$display("clamp test done");
		wr({5'h00, 3'h1, 16'h0038});
		`CHK({lgnd, gp_oe_n, gp_o[1]}, 4'hb)
		wr({5'h00, 3'h0, 16'h0000});
		`CHK({rd[18:16], rd[5:0]}, 9'h078)
		wr({5'h00, 3'h1, 16'h0007});
		`CHK({lgnd, gp_oe_n, gp_o, sdo_oe_n}, 6'h13)
		$display("port test done");
		print_verdict();
	end
endmodule : qdac_regdec_test
